// >>> core/rms_seq.sv
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module rms_seq #(
    parameter int MID_CYC = rms_pkg::STEP_MID_NS / rms_pkg::CLK_NS,
    parameter int LONG_CYC = rms_pkg::STEP_LONG_NS / rms_pkg::CLK_NS
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Register port.
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Chip context.
    input wire logic fsk_modem_sel,
    input wire logic [2:0] chip_mode_in,
    input wire logic crc_enabled,
    input wire logic bad_frame_auto_discard,
    input wire logic freq_changed,
    // Packet engine events, one-cycle pulses.
    input wire logic frame_sent_irq,
    input wire logic payload_available_irq,
    input wire logic check_passed_irq,
    input wire logic rx_signal_level_timeout,
    input wire logic rx_preamble_timeout,
    input wire logic rx_sync_timeout,
    input wire logic signal_strength_irq,
    input wire logic sync_match_irq,
    input wire logic preamble_seen_irq,
    input wire logic queue_level_irq,
    input wire logic queue_drained_irq,
    // Mode control outputs.
    output logic seq_active,
    output logic [2:0] seq_mode,
    output logic receiver_restart,
    output logic first_timer_irq,
    output logic second_timer_irq
);

    // Stored configuration and state.
    logic [13:0] cfg_r; // Transition selectors.
    logic [23:0] timer_r; // Step sizes and multipliers.
    logic [2:0] init_mode_r; // Low-power mode seen at launch.
    rms_pkg::rms_state_t state_r, state_nxt;
    logic [2:0] mode_nxt;
    logic restart_nxt;
    logic [31:0] rdata_nxt;
    logic [15:0] ctrl_view;

    // Field views of the control word.
    logic idle_low_power_select;
    logic low_power_target_select;
    logic [1:0] start_transition_select;
    logic idle_exit_select;
    logic transmit_exit_select;
    logic [2:0] receive_exit_select;
    logic [1:0] receive_expiry_exit_select;
    logic [2:0] packet_received_exit_select;
    logic ctrl_wr; // Write to the control word this cycle.
    assign ctrl_view = {cfg_r, 2'b00};
    assign idle_low_power_select = ctrl_view[rms_pkg::CTRL_IDLE_LP];
    assign low_power_target_select = ctrl_view[rms_pkg::CTRL_LP_TARGET];
    // The launch write carries its own start selector, so one write configures and launches.
    assign start_transition_select = ctrl_wr ? wdata[rms_pkg::CTRL_START_LO +: 2]
                                             : ctrl_view[rms_pkg::CTRL_START_LO +: 2]; // see R2
    assign idle_exit_select = ctrl_view[rms_pkg::CTRL_IDLE_EXIT];
    assign transmit_exit_select = ctrl_view[rms_pkg::CTRL_TX_EXIT];
    assign receive_exit_select = ctrl_view[rms_pkg::CTRL_RX_EXIT_LO +: 3];
    assign receive_expiry_exit_select = ctrl_view[rms_pkg::CTRL_EXPIRY_LO +: 2];
    assign packet_received_exit_select = ctrl_view[rms_pkg::CTRL_PKT_EXIT_LO +: 3];

    // Register strobes decoded from the port.
    logic timer_wr, launch_bit, stop_bit, launch_ok, stop_req;
    assign ctrl_wr = wr && (addr == rms_pkg::ADDR_CTRL);
    assign timer_wr = wr && (addr == rms_pkg::ADDR_TIMER);
    assign launch_bit = ctrl_wr && wdata[rms_pkg::CTRL_LAUNCH];
    assign stop_bit = ctrl_wr && wdata[rms_pkg::CTRL_STOP];
    // Stop wins over a launch written with it, the safer outcome of a misuse.
    assign stop_req = stop_bit || (state_r != rms_pkg::RMS_OFF && !fsk_modem_sel); // see R18
    // Launch only from Off, with the FSK/OOK modem, from Sleep or Standby.
    assign launch_ok = launch_bit && !stop_bit && fsk_modem_sel // see R20
        && state_r == rms_pkg::RMS_OFF
        && (chip_mode_in == rms_pkg::MODE_SLEEP || chip_mode_in == rms_pkg::MODE_STDBY); // see R19

    // Receive event decoding.
    logic rx_timeout, bad_payload, crc_path, timeout_path, rx_exit_hit, rx_off_hit;
    assign rx_timeout = rx_signal_level_timeout || rx_preamble_timeout || rx_sync_timeout; // see R12
    assign crc_path = (receive_exit_select == 3'h3);
    // A payload that did not pass the check is only seen when not auto-discarded.
    assign bad_payload = crc_path && payload_available_irq && !check_passed_irq
        && crc_enabled && !bad_frame_auto_discard; // see R8
    assign timeout_path = rx_timeout || bad_payload; // see R11
    assign rx_exit_hit = (receive_exit_select == 3'h1 && payload_available_irq)
        || (receive_exit_select == 3'h2 && payload_available_irq)
        || (crc_path && check_passed_irq); // see R7
    assign rx_off_hit = (receive_exit_select == 3'h4 && signal_strength_irq)
        || (receive_exit_select == 3'h5 && sync_match_irq)
        || (receive_exit_select == 3'h6 && preamble_seen_irq); // see R9

    // Timer chain: first timer after launch or second timer, second after first.
    logic t1_fire, t2_fire, timers_halt;
    assign timers_halt = state_nxt == rms_pkg::RMS_OFF;
    assign first_timer_irq = t1_fire;
    assign second_timer_irq = t2_fire;

    rms_timer #(.MID_CYC(MID_CYC), .LONG_CYC(LONG_CYC)) u_first (
        .mclk(mclk),
        .rst_n(rst_n),
        .start(launch_ok || t2_fire), // see R14
        .halt(timers_halt),
        .step_sel(timer_r[rms_pkg::TMR_STEP1_LO +: 2]),
        .mult(timer_r[rms_pkg::TMR_MULT1_LO +: 8]),
        .fire(t1_fire)
    );

    rms_timer #(.MID_CYC(MID_CYC), .LONG_CYC(LONG_CYC)) u_second (
        .mclk(mclk),
        .rst_n(rst_n),
        .start(t1_fire), // see R15
        .halt(timers_halt),
        .step_sel(timer_r[rms_pkg::TMR_STEP2_LO +: 2]),
        .mult(timer_r[rms_pkg::TMR_MULT2_LO +: 8]),
        .fire(t2_fire)
    );

    // Next-state logic; the timers run on whatever state this selects.
    always_comb begin // see R17
        state_nxt = state_r;
        restart_nxt = 1'b0;
        unique case (state_r)
            rms_pkg::RMS_OFF: begin
                if (launch_ok) begin
                    unique case (start_transition_select) // see R2
                        2'b00: state_nxt = rms_pkg::RMS_LPS;
                        2'b01: state_nxt = rms_pkg::RMS_RX;
                        2'b10: state_nxt = rms_pkg::RMS_TX;
                        2'b11: state_nxt = rms_pkg::RMS_WAITQ;
                    endcase
                end
            end
            rms_pkg::RMS_WAITQ: begin
                // Chip stays in its initial mode until the queue fills.
                if (queue_level_irq) begin
                    state_nxt = rms_pkg::RMS_TX; // see R2
                end
            end
            rms_pkg::RMS_LPS: begin
                // Transitory: decided on the very next edge.
                state_nxt = low_power_target_select ? rms_pkg::RMS_IDLE
                                                    : rms_pkg::RMS_OFF; // see R3 see R22
            end
            rms_pkg::RMS_IDLE: begin
                if (t1_fire) begin // see R21
                    state_nxt = idle_exit_select ? rms_pkg::RMS_RX : rms_pkg::RMS_TX; // see R5
                end
            end
            rms_pkg::RMS_TX: begin
                if (frame_sent_irq) begin
                    state_nxt = transmit_exit_select ? rms_pkg::RMS_RX
                                                     : rms_pkg::RMS_LPS; // see R6
                end
            end
            rms_pkg::RMS_RX: begin
                // Second timer outranks every receive exit.
                if (t2_fire) begin
                    state_nxt = rms_pkg::RMS_LPS; // see R10
                end else if (rx_exit_hit) begin
                    state_nxt = (receive_exit_select == 3'h2) ? rms_pkg::RMS_LPS
                                                              : rms_pkg::RMS_PKT; // see R7
                end else if (rx_off_hit) begin
                    state_nxt = rms_pkg::RMS_OFF; // see R9
                end else if (timeout_path) begin
                    unique case (receive_expiry_exit_select) // see R11
                        2'b00: restart_nxt = 1'b1;
                        2'b01: state_nxt = rms_pkg::RMS_TX;
                        2'b10: state_nxt = rms_pkg::RMS_LPS;
                        2'b11: state_nxt = rms_pkg::RMS_OFF;
                    endcase
                end
            end
            rms_pkg::RMS_PKT: begin
                // Codes above 100 are unused and hold the state.
                if (packet_received_exit_select == 3'h0) begin
                    state_nxt = rms_pkg::RMS_OFF; // see R13
                end else if (packet_received_exit_select == 3'h1 && queue_drained_irq) begin
                    state_nxt = rms_pkg::RMS_TX; // see R13
                end else if (packet_received_exit_select == 3'h2) begin
                    state_nxt = rms_pkg::RMS_LPS; // see R13
                end else if (packet_received_exit_select == 3'h3) begin
                    state_nxt = freq_changed ? rms_pkg::RMS_SYNTH : rms_pkg::RMS_RX; // see R13
                end else if (packet_received_exit_select == 3'h4) begin
                    state_nxt = rms_pkg::RMS_RX; // see R13
                end
            end
            rms_pkg::RMS_SYNTH: begin
                // One cycle of synthesiser-only mode to relock before receiving.
                state_nxt = rms_pkg::RMS_RX; // see R13
            end
        endcase
        if (stop_req) begin
            state_nxt = rms_pkg::RMS_OFF; // see R18
            restart_nxt = 1'b0;
        end
    end

    // Chip mode requested for the next state; Off returns to the launch mode.
    always_comb begin
        unique case (state_nxt)
            rms_pkg::RMS_IDLE: mode_nxt = idle_low_power_select ? rms_pkg::MODE_SLEEP
                                                               : rms_pkg::MODE_STDBY; // see R1
            rms_pkg::RMS_TX: mode_nxt = rms_pkg::MODE_TX;
            rms_pkg::RMS_RX: mode_nxt = rms_pkg::MODE_RX;
            rms_pkg::RMS_PKT: mode_nxt = rms_pkg::MODE_RX;
            rms_pkg::RMS_SYNTH: mode_nxt = rms_pkg::MODE_SYNTH;
            rms_pkg::RMS_OFF: mode_nxt = init_mode_r; // see R4
            rms_pkg::RMS_LPS: mode_nxt = seq_mode;
            rms_pkg::RMS_WAITQ: mode_nxt = init_mode_r;
        endcase
        if (launch_ok) begin
            // Start from the mode seen now, before the capture lands.
            mode_nxt = (state_nxt == rms_pkg::RMS_LPS || state_nxt == rms_pkg::RMS_WAITQ)
                ? chip_mode_in : mode_nxt;
        end
    end

    // Read multiplexer; data appears only in the cycle after the strobe.
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (rd) begin
            unique case (addr)
                rms_pkg::ADDR_CTRL: rdata_nxt = {16'h0000, ctrl_view};
                rms_pkg::ADDR_TIMER: rdata_nxt = {8'h00, timer_r};
                rms_pkg::ADDR_STATUS: rdata_nxt = {22'h000000, seq_active, init_mode_r,
                                                   seq_mode, state_r};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // Configuration registers; launch and stop are self-clearing strobes.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= rms_pkg::CTRL_CFG_RESET;
            timer_r <= rms_pkg::TIMER_RESET;
        end else begin
            if (ctrl_wr) begin
                cfg_r <= wdata[rms_pkg::CTRL_CFG_HI:rms_pkg::CTRL_CFG_LO];
            end
            if (timer_wr) begin
                timer_r <= wdata[rms_pkg::TMR_HI:0];
            end
        end
    end

    // Sequencer state, outputs and the captured initial mode.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= rms_pkg::RMS_OFF;
            seq_active <= 1'b0;
            seq_mode <= rms_pkg::MODE_SLEEP;
            receiver_restart <= 1'b0;
            init_mode_r <= rms_pkg::MODE_SLEEP;
            rdata <= 32'h00000000;
        end else begin
            state_r <= state_nxt;
            seq_active <= state_nxt != rms_pkg::RMS_OFF;
            seq_mode <= mode_nxt;
            receiver_restart <= restart_nxt; // see R11
            rdata <= rdata_nxt;
            if (launch_ok) begin
                init_mode_r <= chip_mode_in; // see R4
            end
        end
    end

    // Checks on the transitions.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_rx_t2;
        state_r == rms_pkg::RMS_RX && t2_fire && !stop_req;
    endsequence
    sequence s_lps_then_off;
        state_r == rms_pkg::RMS_LPS ##1 state_r == rms_pkg::RMS_OFF;
    endsequence

    chk_idle_mode: assert property (state_r == rms_pkg::RMS_IDLE |-> // see R1
        seq_mode == (idle_low_power_select ? rms_pkg::MODE_SLEEP : rms_pkg::MODE_STDBY))
        else $error("idle chip mode wrong");
    chk_start_rx: assert property (launch_ok && start_transition_select == 2'b01 // see R2
        |=> state_r == rms_pkg::RMS_RX && seq_mode == rms_pkg::MODE_RX)
        else $error("launch to receive failed");
    chk_lps_resolve: assert property (state_r == rms_pkg::RMS_LPS // see R22
        |=> state_r == rms_pkg::RMS_OFF || state_r == rms_pkg::RMS_IDLE)
        else $error("low-power selection lingered");
    chk_lps_restore: assert property (s_lps_then_off // see R4
        |-> seq_mode == init_mode_r && !seq_active)
        else $error("initial mode not restored");
    chk_idle_exit: assert property (state_r == rms_pkg::RMS_IDLE && t1_fire && !stop_req // see R5
        |=> state_r == (idle_exit_select ? rms_pkg::RMS_RX : rms_pkg::RMS_TX))
        else $error("idle exit wrong");
    chk_idle_deaf: assert property (state_r == rms_pkg::RMS_IDLE && !t1_fire && !stop_req // see R21
        |=> state_r == rms_pkg::RMS_IDLE)
        else $error("idle left without first timer");
    chk_tx_exit: assert property (state_r == rms_pkg::RMS_TX && frame_sent_irq && !stop_req // see R6
        |=> state_r == (transmit_exit_select ? rms_pkg::RMS_RX : rms_pkg::RMS_LPS))
        else $error("transmit exit wrong");
    chk_rx_second: assert property (s_rx_t2 |=> state_r == rms_pkg::RMS_LPS // see R10
        ##1 state_r != rms_pkg::RMS_LPS)
        else $error("second timer exit wrong");
    chk_stop_off: assert property (stop_bit |=> state_r == rms_pkg::RMS_OFF && !seq_active) // see R18
        else $error("stop did not turn off");
    chk_restart_pulse: assert property (receiver_restart // see R11
        |-> state_r == rms_pkg::RMS_RX ##1 !receiver_restart)
        else $error("restart pulse wrong");
    chk_second_off: assert property (t1_fire && timer_r[rms_pkg::TMR_STEP2_LO +: 2] == 2'b00 // see R15
        && !timer_wr |=> !t2_fire [*8])
        else $error("disabled second timer fired");

endmodule // rms_seq

// >>> core/rms_pkg.sv
// Behaviour
// R1: Idle holds Standby or Sleep per select.
// R2: Launch branches by start transition select.
// R3: Low-power selection goes Off or Idle.
// R4: Record launch mode, restore it when off.
// R5: Idle exits on first timer, Tx/Rx.
// R6: Transmit exits on frame sent, LPS/Rx.
// R7: Receive exits on payload or check passed.
// R8: Bad CRC payload under 011 means timeout.
// R9: Receive codes 100-110 stop on events.
// R10: Second timer in Receive goes low-power.
// R11: Receive expiry select picks timeout destination.
// R12: Any of three timeouts is receive timeout.
// R13: Packet received exit select picks destination.
// R14: First timer fires after second or launch.
// R15: Second timer fires after first timer.
// R16: Step codes: off, 64us, 4.1ms, 262ms.
// R17: Timers alternate regardless of sequencer state; here both halt whenever the next state is Off.
// R18: Stop bit turns sequencer off immediately.
// R19: Software launches only from Sleep/Standby, never with stop.
// R20: Sequencer works only with FSK/OOK modem.
// R21: Idle ignores everything except first timer.
// R22: Low-power selection resolves within one cycle.
// R23: Multiplier is 8-bit count of step periods.
package rms_pkg;

    // Register word addresses on the byte-addressed port.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TIMER = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // Control register field positions.
    localparam int CTRL_LAUNCH = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_IDLE_LP = 2;
    localparam int CTRL_LP_TARGET = 3;
    localparam int CTRL_START_LO = 4;
    localparam int CTRL_IDLE_EXIT = 6;
    localparam int CTRL_TX_EXIT = 7;
    localparam int CTRL_RX_EXIT_LO = 8;
    localparam int CTRL_EXPIRY_LO = 11;
    localparam int CTRL_PKT_EXIT_LO = 13;
    localparam int CTRL_CFG_LO = 2;
    localparam int CTRL_CFG_HI = 15;

    // Timer register field positions.
    localparam int TMR_STEP1_LO = 0;
    localparam int TMR_STEP2_LO = 2;
    localparam int TMR_MULT1_LO = 8;
    localparam int TMR_MULT2_LO = 16;
    localparam int TMR_HI = 23;

    // Reset values of the stored configuration.
    localparam logic [13:0] CTRL_CFG_RESET = 14'h0000;
    localparam logic [23:0] TIMER_RESET = 24'h000000;

    // Chip mode codes driven towards the radio mode control.
    localparam logic [2:0] MODE_SLEEP = 3'h0;
    localparam logic [2:0] MODE_STDBY = 3'h1;
    localparam logic [2:0] MODE_SYNTH = 3'h2;
    localparam logic [2:0] MODE_TX = 3'h3;
    localparam logic [2:0] MODE_RX = 3'h5;

    // Timing: clock period and step sizes in nanoseconds.
    localparam int CLK_NS = 20;
    localparam int STEP_SHORT_NS = 64000;
    localparam int STEP_MID_NS = 4100000;
    localparam int STEP_LONG_NS = 262000000;
    localparam int STEP_SHORT_CYC = STEP_SHORT_NS / CLK_NS;

    // Sequencer states.
    typedef enum logic [2:0] {
        RMS_OFF = 3'b000,
        RMS_IDLE = 3'b001,
        RMS_TX = 3'b010,
        RMS_RX = 3'b011,
        RMS_PKT = 3'b100,
        RMS_LPS = 3'b101,
        RMS_WAITQ = 3'b110,
        RMS_SYNTH = 3'b111
    } rms_state_t;

endpackage

// >>> core/rms_timer.sv
`timescale 1ns/1ps
module rms_timer #(
    parameter int MID_CYC = 205000,
    parameter int LONG_CYC = 13100000
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Control.
    input wire logic start,
    input wire logic halt,
    input wire logic [1:0] step_sel,
    input wire logic [7:0] mult,
    // Expiry pulse, one cycle.
    output logic fire
);

    // Step code to cycles per count; zero means the timer is off.
    function automatic logic [23:0] period_of(input logic [1:0] sel);
        unique case (sel)
            2'b00: period_of = 24'h000000;
            2'b01: period_of = 24'(rms_pkg::STEP_SHORT_CYC); // see R16
            2'b10: period_of = 24'(MID_CYC); // see R16
            2'b11: period_of = 24'(LONG_CYC); // see R16
        endcase
    endfunction

    logic armed_r; // Counting towards expiry.
    logic [23:0] pre_r; // Cycles within one step.
    logic [7:0] cnt_r; // Steps still to run.
    logic [23:0] period; // Current step length.
    logic step_done; // Last cycle of a step.
    logic arm_ok; // Step and multiplier both non-zero.

    assign period = period_of(step_sel);
    assign step_done = armed_r && (pre_r == period - 24'h000001);
    // A zero multiplier is taken as off, since zero steps has no sensible delay.
    assign arm_ok = (step_sel != 2'b00) && (mult != 8'h00);

    // Step prescaler and multiplier countdown.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            armed_r <= 1'b0;
            pre_r <= 24'h000000;
            cnt_r <= 8'h00;
            fire <= 1'b0;
        end else begin
            fire <= 1'b0;
            if (halt) begin
                armed_r <= 1'b0;
            end else if (start) begin
                // Restart wins over everything but halt, so a new cycle begins on each trigger outside halt.
                armed_r <= arm_ok; // see R16
                pre_r <= 24'h000000;
                cnt_r <= mult; // see R23
            end else if (step_done) begin
                pre_r <= 24'h000000;
                cnt_r <= cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    armed_r <= 1'b0;
                    fire <= 1'b1; // see R23
                end
            end else if (armed_r) begin
                pre_r <= pre_r + 24'h000001;
            end
        end
    end

endmodule // rms_timer

// >>> dv/rms_engine_model.sv
`timescale 1ns/1ps
module rms_engine_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Event request from the bench, with a delay in cycles.
    input wire logic [10:0] ev_cmd,
    input wire logic [3:0] ev_lag,
    // Mode requested by the sequencer.
    input wire logic [2:0] seq_mode,
    // One-cycle event pulses towards the sequencer.
    output logic [10:0] ev_out
);
    logic [10:0] pend_r;
    logic [3:0] cnt_r;
    // A radio cannot report a sent frame outside transmit or a packet outside receive.
    wire logic [10:0] gate = {2'b11, {8{seq_mode == rms_pkg::MODE_RX}},
        seq_mode == rms_pkg::MODE_TX};

    // Hold a request for its delay, then emit it as a single pulse.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= 11'h000;
            cnt_r <= 4'h0;
            ev_out <= 11'h000;
        end else if (ev_cmd != 11'h000) begin
            pend_r <= ev_cmd;
            cnt_r <= ev_lag;
            ev_out <= 11'h000;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end else begin
            ev_out <= pend_r & gate;
            pend_r <= 11'h000;
        end
    end
endmodule // rms_engine_model

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
    logic mclk, rst_n, wr, rd, fsk, seq_active, restart, t1, t2, discard;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [2:0] chip_mode, seq_mode;
    logic [10:0] ev_cmd, ev;
    logic [3:0] lag;
    int err_count, compares, cyc, t_a, t_b, g12, g21, n_rst;
    logic [22:0] rows [20];

    // Short step counts keep the timer scenario brief.
    rms_seq #(.MID_CYC(50), .LONG_CYC(100)) dut (.mclk(mclk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fsk_modem_sel(fsk),
        .chip_mode_in(chip_mode), .crc_enabled(1'b1), .bad_frame_auto_discard(discard),
        .freq_changed(1'b1), .frame_sent_irq(ev[0]), .payload_available_irq(ev[1]),
        .check_passed_irq(ev[2]), .rx_signal_level_timeout(ev[3]),
        .rx_preamble_timeout(ev[4]), .rx_sync_timeout(ev[5]), .signal_strength_irq(ev[6]),
        .sync_match_irq(ev[7]), .preamble_seen_irq(ev[8]), .queue_level_irq(ev[9]),
        .queue_drained_irq(ev[10]), .seq_active(seq_active), .seq_mode(seq_mode),
        .receiver_restart(restart), .first_timer_irq(t1), .second_timer_irq(t2));
    rms_engine_model peer (.mclk(mclk), .rst_n(rst_n), .ev_cmd(ev_cmd), .ev_lag(lag),
        .seq_mode(seq_mode), .ev_out(ev));

    // Free-running clock.
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Row layout: expected state, event index (F for none), control fields.
    function automatic logic [22:0] mk(input int s, lp, te, re, ex, pk, e, st);
        return {st[2:0], e[3:0], pk[2:0], ex[1:0], re[2:0], te[0], 1'b0, s[1:0], lp[0], 3'h0};
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // Read data is only valid in the cycle after the strobe.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask

    task automatic wait_irq(input logic sel);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while ((sel ? t2 : t1) !== 1'b1 && n < 400);
        chk({31'h0, sel ? t2 : t1}, 32'h1);
    endtask

    // One row: stop, launch with the row's fields, fire at most one event, read the state.
    task automatic run_row(input logic [22:0] r, input int l);
        lag <= 4'(l);
        wr_reg(rms_pkg::ADDR_CTRL, 32'h2);
        rd_chk(rms_pkg::ADDR_STATUS, 32'h7, 32'h0);
        wr_reg(rms_pkg::ADDR_CTRL, {16'h0, r[15:0]} | 32'h1);
        if (r[19:16] != 4'hF) begin
            @(posedge mclk);
            ev_cmd <= 11'(1 << r[19:16]);
            @(posedge mclk);
            ev_cmd <= 11'h000;
        end
        repeat (8) @(posedge mclk);
        rd_chk(rms_pkg::ADDR_STATUS, 32'h7, {29'h0, r[22:20]});
    endtask

    task automatic wrap_up();
        $display("err_count=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Timer pulse spacing and restart pulses are measured in the background.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (t1 === 1'b1) begin
            t_a <= cyc;
            g21 <= cyc - t_b;
        end
        if (t2 === 1'b1) begin
            t_b <= cyc;
            g12 <= cyc - t_a;
        end
        if (restart === 1'b1) begin
            n_rst <= n_rst + 1;
        end
    end

    // Watchdog, far beyond the expected run of about eight hundred cycles.
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        fsk = 1'b1;
        discard = 1'b0;
        chip_mode = 3'h1;
        ev_cmd = 11'h000;
        lag = 4'h0;
        rows = '{mk(2,0,1,0,0,0,0,3), mk(2,1,0,0,0,0,0,1), mk(1,0,0,1,0,1,1,4),
            mk(1,1,0,2,0,0,1,1), mk(1,0,0,3,0,5,2,4), mk(1,0,0,3,1,0,1,2),
            mk(1,0,0,4,0,0,6,0), mk(1,0,0,5,0,0,7,0), mk(1,0,0,6,0,0,8,0),
            mk(1,0,0,0,1,0,3,2), mk(1,1,0,0,2,0,4,1), mk(1,0,0,0,3,0,5,0),
            mk(1,0,0,0,0,0,5,3), mk(3,0,0,0,0,0,9,2), mk(0,1,0,0,0,0,9,1),
            mk(0,0,0,0,0,0,15,0), mk(1,0,0,1,0,0,1,0), mk(1,0,0,1,0,3,1,3),
            mk(1,1,0,1,0,2,1,1), mk(1,0,0,1,0,4,1,3)};
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        rd_chk(rms_pkg::ADDR_STATUS, 32'h3FF, 32'h0);
        rd_chk(8'h0C, 32'hFFFFFFFF, 32'h0);
        // Each row stops the sequencer, launches it and fires at most one event.
        foreach (rows[i]) begin
            run_row(rows[i], i % 4);
        end
        // With auto-discard on, a payload that failed its check is dropped and Rx holds.
        discard <= 1'b1;
        run_row(mk(1,0,0,3,1,0,1,3), 0);
        discard <= 1'b0;
        chk(n_rst, 1);
        rd_chk(rms_pkg::ADDR_CTRL, 32'h3, 32'h0);
        // Returning to Off must restore the standby mode seen at launch.
        wr_reg(rms_pkg::ADDR_CTRL, 32'h2);
        wr_reg(rms_pkg::ADDR_CTRL, 32'h1);
        repeat (3) @(posedge mclk);
        rd_chk(rms_pkg::ADDR_STATUS, 32'h1FF, 32'h48);
        fsk <= 1'b0;
        wr_reg(rms_pkg::ADDR_CTRL, 32'h11);
        rd_chk(rms_pkg::ADDR_STATUS, 32'h7, 32'h0);
        fsk <= 1'b1;
        // Timers at mid step: first counts two steps, second three.
        wr_reg(rms_pkg::ADDR_TIMER, 32'h0003020A);
        wr_reg(rms_pkg::ADDR_CTRL, 32'h4D);
        repeat (3) @(posedge mclk);
        rd_chk(rms_pkg::ADDR_STATUS, 32'h3F, 32'h01);
        wait_irq(1'b0);
        repeat (3) @(posedge mclk);
        rd_chk(rms_pkg::ADDR_STATUS, 32'h7, 32'h3);
        wait_irq(1'b1);
        repeat (3) @(posedge mclk);
        rd_chk(rms_pkg::ADDR_STATUS, 32'h7, 32'h1);
        wait_irq(1'b0);
        repeat (2) @(posedge mclk);
        chk(g12 - g21, 50);
        chk(32'(g21 >= 100 && g21 <= 102), 1);
        wrap_up();
    end
endmodule // tb
